// [logic/bdt_list_scan.sv]
// Register list scanner: lowest two selected indices and the count.
// Assumes a purely combinational use by the sequencer.
`default_nettype none
module bdt_list_scan #(
  parameter int NREG = 16
) (
  input wire logic [NREG-1:0] list,
  output logic first_vld,
  output logic [3:0] first_idx,
  output logic [3:0] second_idx,
  output logic [4:0] count
);
  // Scan from the top so the lowest set bits win
  always_comb begin
    first_vld = 1'b0;
    first_idx = 4'h0;
    second_idx = 4'h0;
    count = 5'h00;
    for (int i = NREG - 1; i >= 0; i--) begin
      if (list[i]) begin
        second_idx = first_idx;
        first_idx = 4'(i);
        first_vld = 1'b1;
        count = count + 5'h01;
      end
    end
  end
endmodule : bdt_list_scan
`default_nettype wire

// [logic/bdt_params.svh]
// Constants for the block load / block store sequencer.
// Assumes a 32-bit core with sixteen general registers, index 15 the program counter.
// Contract
// - Register list bit i selects register i
// - Stored program counter equals instruction address plus 12
// - Ascending order; lowest register at lowest address
// - Addresses from base, pre/post and up/down
// - No write-back keeps base unless loaded
// - Unaligned base unchanged; low bits still driven
// - Load with flag and counter restores status
// - Flag otherwise selects user register bank
// - Write-back ends cycle two; first store original
// - Loaded base replaces written-back base value
// - Abort possible on any transfer, recoverable
// - Store abort: finish, trap, only write-back
// - Load abort stops register updates at abort
// - Load abort restores base to proper value
// - Load abort trap only after sequence ends
// - Cycle counts per load, counter load, store
// - Stack kinds fix pre/post and up/down
`ifndef BDT_PARAMS_SVH
`define BDT_PARAMS_SVH
`define BDT_WORD_STEP 32'h0000_0004
`define BDT_PC_STORE_OFS 32'h0000_000c
`define BDT_PC_IDX 4'hf
`define BDT_RST_WORD 32'h0000_0000
`define BDT_RST_IDX 4'h0
`endif

// [logic/bdt_pkg.sv]
// Types shared by the block transfer sequencer.
// Assumes nothing beyond a SystemVerilog package scope.
`default_nettype none
package bdt_pkg;
  // Decoded fields of a block transfer instruction
  typedef struct packed {
    logic load;
    logic pre;
    logic up;
    logic sbit;
    logic wback;
    logic [3:0] base_idx;
    logic [15:0] reg_list;
  } bdt_instr_t;

  // Bus cycle class: internal, non-sequential, sequential
  typedef enum logic [1:0] {
    BDT_CYC_I = 2'b00,
    BDT_CYC_N = 2'b01,
    BDT_CYC_S = 2'b10
  } bdt_cycle_t;

  typedef enum logic [2:0] {
    BDT_IDLE = 3'b000,
    BDT_ADDR = 3'b001,
    BDT_XFER = 3'b010,
    BDT_INTL = 3'b011,
    BDT_FILL1 = 3'b100,
    BDT_FILL2 = 3'b101
  } bdt_state_t;
endpackage : bdt_pkg
`default_nettype wire

// [logic/bdt_unit.sv]
// Block load / block store sequencer: addresses, register traffic, abort recovery.
// Assumes a register file with a combinational read port and two write ports,
// and a memory system that answers read data and abort in the transfer cycle.
`include "bdt_params.svh"
`default_nettype none
module bdt_unit (
  input wire logic clk,
  input wire logic nrst,
  input wire logic start,
  input wire bdt_pkg::bdt_instr_t instr,
  input wire logic [31:0] instr_addr,
  input wire logic [31:0] base_value,
  input wire logic [31:0] rf_rdata,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_abort,
  output logic busy,
  output logic done,
  output logic abort_trap,
  output logic mem_req,
  output logic mem_write,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  output bdt_pkg::bdt_cycle_t cycle_kind,
  output logic [3:0] rf_raddr,
  output logic rf_user,
  output logic rf_we,
  output logic [3:0] rf_widx,
  output logic [31:0] rf_wdata,
  output logic base_we,
  output logic [3:0] base_widx,
  output logic [31:0] base_wdata,
  output logic psr_restore
);
  bdt_pkg::bdt_state_t state, next_state;
  bdt_pkg::bdt_instr_t ins, next_ins;
  logic [15:0] list_left, next_list_left;
  logic [31:0] pc_addr, next_pc_addr;
  logic [31:0] base_orig, next_base_orig;
  logic [31:0] wb_val, next_wb_val;
  logic [31:0] lo_addr, next_lo_addr;
  logic [31:0] addr, next_addr;
  logic [3:0] xfer_idx, next_xfer_idx;
  logic aborted, next_aborted;
  logic next_busy, next_done, next_abort_trap, next_mem_req, next_mem_write;
  logic [31:0] next_mem_addr, next_mem_wdata, next_rf_wdata, next_base_wdata;
  bdt_pkg::bdt_cycle_t next_cycle_kind;
  logic [3:0] next_rf_raddr, next_rf_widx, next_base_widx;
  logic next_rf_user, next_rf_we, next_base_we, next_psr_restore;

  logic [15:0] scan_list;
  logic scan_vld;
  logic [3:0] scan_first, scan_second;
  logic [4:0] scan_count;
  logic [31:0] span;

  // Before start the scanner looks at the incoming list, later at what is left
  assign scan_list = (state == bdt_pkg::BDT_IDLE) ? instr.reg_list : list_left;
  assign span = {25'h0, scan_count, 2'b00};

  bdt_list_scan #(.NREG(16)) u_scan (
    .list(scan_list),
    .first_vld(scan_vld),
    .first_idx(scan_first),
    .second_idx(scan_second),
    .count(scan_count)
  );

  // Store data: counter reads as instruction address plus 12, base later than
  // first reads as its written-back value since the file updates only at cycle two end
  function automatic logic [31:0] store_val(input logic [3:0] idx, input logic first);
    logic [31:0] v;
    v = rf_rdata;
    if (idx == `BDT_PC_IDX) begin
      v = pc_addr + `BDT_PC_STORE_OFS;
    end else if (!first && ins.wback && idx == ins.base_idx) begin
      v = wb_val;
    end
    return v;
  endfunction : store_val

  // Sequencer next state and every registered output
  always_comb begin
    next_state = state;
    next_ins = ins;
    next_list_left = list_left;
    next_pc_addr = pc_addr;
    next_base_orig = base_orig;
    next_wb_val = wb_val;
    next_lo_addr = lo_addr;
    next_addr = addr;
    next_xfer_idx = xfer_idx;
    next_aborted = aborted;
    next_busy = busy;
    next_done = 1'b0;
    next_abort_trap = 1'b0;
    next_mem_req = 1'b0;
    next_mem_write = 1'b0;
    next_mem_addr = mem_addr;
    next_mem_wdata = mem_wdata;
    next_cycle_kind = bdt_pkg::BDT_CYC_I;
    next_rf_raddr = rf_raddr;
    next_rf_user = rf_user;
    next_rf_we = 1'b0;
    next_rf_widx = rf_widx;
    next_rf_wdata = rf_wdata;
    next_base_we = 1'b0;
    next_base_widx = base_widx;
    next_base_wdata = base_wdata;
    next_psr_restore = 1'b0;
    unique case (state)
      bdt_pkg::BDT_IDLE: begin
        if (start) begin
          next_state = bdt_pkg::BDT_ADDR;
          next_ins = instr;
          next_list_left = instr.reg_list;
          next_pc_addr = instr_addr;
          next_base_orig = base_value;
          // Low address bits ride along untouched
          if (instr.up) begin
            next_lo_addr = instr.pre ? base_value + `BDT_WORD_STEP : base_value;
            next_wb_val = base_value + span;
          end else begin
            next_lo_addr = instr.pre ? base_value - span
                                     : base_value - span + `BDT_WORD_STEP;
            next_wb_val = base_value - span;
          end
          next_rf_raddr = scan_first;
          // Counter load with the flag restores status instead of banking
          next_rf_user = instr.sbit && !(instr.load && instr.reg_list[15]);
          next_aborted = 1'b0;
          next_busy = 1'b1;
          next_cycle_kind = bdt_pkg::BDT_CYC_N;
        end
      end
      bdt_pkg::BDT_ADDR: begin
        // First transfer goes out at the start of cycle two
        next_state = bdt_pkg::BDT_XFER;
        next_mem_req = 1'b1;
        next_mem_write = !ins.load;
        next_mem_addr = lo_addr;
        next_addr = lo_addr + `BDT_WORD_STEP;
        next_xfer_idx = scan_first;
        next_list_left = list_left & ~(16'h0001 << scan_first);
        next_mem_wdata = store_val(scan_first, 1'b1);
        next_rf_raddr = scan_second;
        next_base_we = ins.wback;
        next_base_widx = ins.base_idx;
        next_base_wdata = wb_val;
        next_cycle_kind = ins.load ? bdt_pkg::BDT_CYC_S : bdt_pkg::BDT_CYC_N;
      end
      bdt_pkg::BDT_XFER: begin
        // Abort is taken on any transfer; loads stop register writes, loads and stores carry on
        if (mem_abort) begin
          next_aborted = 1'b1;
        end else if (ins.load && !aborted) begin
          next_rf_we = 1'b1;
          next_rf_widx = xfer_idx;
          next_rf_wdata = mem_rdata;
          next_psr_restore = ins.sbit && xfer_idx == `BDT_PC_IDX;
        end
        if (scan_vld) begin
          next_mem_req = 1'b1;
          next_mem_write = !ins.load;
          next_mem_addr = addr;
          next_addr = addr + `BDT_WORD_STEP;
          next_xfer_idx = scan_first;
          next_list_left = list_left & ~(16'h0001 << scan_first);
          next_mem_wdata = store_val(scan_first, 1'b0);
          next_rf_raddr = scan_second;
          next_cycle_kind = bdt_pkg::BDT_CYC_S;
        end else if (ins.load) begin
          next_state = bdt_pkg::BDT_INTL;
          next_cycle_kind = bdt_pkg::BDT_CYC_I;
        end else begin
          // Store ends here; trap only after the last word
          next_state = bdt_pkg::BDT_IDLE;
          next_busy = 1'b0;
          next_done = 1'b1;
          next_abort_trap = aborted || mem_abort;
        end
      end
      bdt_pkg::BDT_INTL: begin
        if (aborted) begin
          // Undo any base overwrite left by the partial load
          next_base_we = 1'b1;
          next_base_widx = ins.base_idx;
          next_base_wdata = ins.wback ? wb_val : base_orig;
        end
        if (ins.reg_list[15] && !aborted) begin
          next_state = bdt_pkg::BDT_FILL1;
          next_cycle_kind = bdt_pkg::BDT_CYC_N;
        end else begin
          next_state = bdt_pkg::BDT_IDLE;
          next_busy = 1'b0;
          next_done = 1'b1;
          next_abort_trap = aborted;
        end
      end
      bdt_pkg::BDT_FILL1: begin
        // Refill after a counter load: one more N and one S
        next_state = bdt_pkg::BDT_FILL2;
        next_cycle_kind = bdt_pkg::BDT_CYC_S;
      end
      bdt_pkg::BDT_FILL2: begin
        next_state = bdt_pkg::BDT_IDLE;
        next_busy = 1'b0;
        next_done = 1'b1;
      end
      default: begin
        // Illegal code: drop back to idle
        next_state = bdt_pkg::BDT_IDLE;
        next_busy = 1'b0;
      end
    endcase
  end

  // State and output registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= bdt_pkg::BDT_IDLE;
      ins <= '0;
      list_left <= 16'h0000;
      pc_addr <= `BDT_RST_WORD;
      base_orig <= `BDT_RST_WORD;
      wb_val <= `BDT_RST_WORD;
      lo_addr <= `BDT_RST_WORD;
      addr <= `BDT_RST_WORD;
      xfer_idx <= `BDT_RST_IDX;
      aborted <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      abort_trap <= 1'b0;
      mem_req <= 1'b0;
      mem_write <= 1'b0;
      mem_addr <= `BDT_RST_WORD;
      mem_wdata <= `BDT_RST_WORD;
      cycle_kind <= bdt_pkg::BDT_CYC_I;
      rf_raddr <= `BDT_RST_IDX;
      rf_user <= 1'b0;
      rf_we <= 1'b0;
      rf_widx <= `BDT_RST_IDX;
      rf_wdata <= `BDT_RST_WORD;
      base_we <= 1'b0;
      base_widx <= `BDT_RST_IDX;
      base_wdata <= `BDT_RST_WORD;
      psr_restore <= 1'b0;
    end else begin
      state <= next_state;
      ins <= next_ins;
      list_left <= next_list_left;
      pc_addr <= next_pc_addr;
      base_orig <= next_base_orig;
      wb_val <= next_wb_val;
      lo_addr <= next_lo_addr;
      addr <= next_addr;
      xfer_idx <= next_xfer_idx;
      aborted <= next_aborted;
      busy <= next_busy;
      done <= next_done;
      abort_trap <= next_abort_trap;
      mem_req <= next_mem_req;
      mem_write <= next_mem_write;
      mem_addr <= next_mem_addr;
      mem_wdata <= next_mem_wdata;
      cycle_kind <= next_cycle_kind;
      rf_raddr <= next_rf_raddr;
      rf_user <= next_rf_user;
      rf_we <= next_rf_we;
      rf_widx <= next_rf_widx;
      rf_wdata <= next_rf_wdata;
      base_we <= next_base_we;
      base_widx <= next_base_widx;
      base_wdata <= next_base_wdata;
      psr_restore <= next_psr_restore;
    end
  end

  // Checks on the driven sequence
  chk_pc_store_value: assert property (@(posedge clk) disable iff (!nrst)
    (mem_req && mem_write && xfer_idx == `BDT_PC_IDX) |-> mem_wdata == pc_addr + 32'h0000_000c)
    else $error("stored counter is not instruction address plus 12");
  chk_addr_ascend: assert property (@(posedge clk) disable iff (!nrst)
    (mem_req && $past(mem_req)) |-> (mem_addr == $past(mem_addr) + 32'h0000_0004
      && xfer_idx > $past(xfer_idx)))
    else $error("transfers not ascending by one word");
  chk_first_addr: assert property (@(posedge clk) disable iff (!nrst)
    (state == bdt_pkg::BDT_ADDR && ins.up && !ins.pre) |=> mem_addr == $past(base_orig))
    else $error("increment-after does not start at base");
  chk_wb_at_two: assert property (@(posedge clk) disable iff (!nrst)
    (start && state == bdt_pkg::BDT_IDLE && instr.wback) |=> !base_we ##1
      (base_we && base_wdata == wb_val && base_widx == ins.base_idx))
    else $error("write-back not issued in cycle two");
  chk_no_wb_quiet: assert property (@(posedge clk) disable iff (!nrst)
    (base_we && !ins.wback) |-> (aborted && base_wdata == base_orig))
    else $error("base written without write-back request");
  chk_abort_stops: assert property (@(posedge clk) disable iff (!nrst)
    (state == bdt_pkg::BDT_XFER && ins.load && mem_abort) |=> !rf_we [*2])
    else $error("register written after abort");
  chk_trap_at_end: assert property (@(posedge clk) disable iff (!nrst)
    abort_trap |-> (done && !busy && $past(aborted || mem_abort)))
    else $error("abort trap outside end of sequence");
  chk_psr_with_pc: assert property (@(posedge clk) disable iff (!nrst)
    psr_restore |-> (rf_we && rf_widx == `BDT_PC_IDX && ins.sbit))
    else $error("status restore not tied to counter load");
  chk_user_bank: assert property (@(posedge clk) disable iff (!nrst)
    busy |-> rf_user == (ins.sbit && !(ins.load && ins.reg_list[15])))
    else $error("user bank select wrong");
  chk_list_bit: assert property (@(posedge clk) disable iff (!nrst)
    rf_we |-> ins.reg_list[rf_widx])
    else $error("loaded register not in list");
  chk_store_len: assert property (@(posedge clk) disable iff (!nrst)
    (state == bdt_pkg::BDT_ADDR && !ins.load && scan_count == 5'h01)
      |=> mem_req ##1 (done && !busy))
    else $error("single store not two cycles after decode");
  chk_restore_base: assert property (@(posedge clk) disable iff (!nrst)
    (state == bdt_pkg::BDT_INTL && aborted) |=> (base_we
      && base_wdata == (ins.wback ? wb_val : base_orig)))
    else $error("base not restored after load abort");
endmodule : bdt_unit
`default_nettype wire

// [testbench/bdt_mem_model.sv]
// Memory system and memory manager model facing the block transfer sequencer.
// Assumes one transfer per cycle shown by mem_req; the bench names the aborting transfer.
`default_nettype none
module bdt_mem_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic [4:0] abort_at,
  output logic [31:0] mem_rdata,
  output logic mem_abort,
  output logic [4:0] nxfer
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] noise;
  // Transfer counter per instruction; noise keeps idle read data moving
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      nxfer <= 5'h00;
      noise <= 32'h5a5a_0000;
    end else begin
      noise <= noise + 32'h0001_0003;
      if (start) begin
        nxfer <= 5'h00;
      end else if (mem_req) begin
        nxfer <= nxfer + 5'h01;
      end
    end
  end
  // Read data is the inverted address, so a wrong address shows as wrong data
  assign mem_rdata = mem_req ? ~mem_addr : noise;
  // Any chosen transfer may abort; 1f never matches a real position
  assign mem_abort = mem_req && (nxfer == abort_at);
  // Stores are never committed here, so an aborted write cannot land
endmodule : bdt_mem_model
`default_nettype wire

// [testbench/bdt_unit_tb.sv]
// Self-checking bench for the block load / block store sequencer.
// Assumes the memory model beside it and a small register file kept here.
`include "bdt_params.svh"
`default_nettype none
module bdt_unit_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, nrst, start, mem_abort, busy, done, abort_trap, mem_req, mem_write;
  logic rf_user, rf_we, base_we, psr_restore;
  logic [3:0] rf_raddr, rf_widx, base_widx;
  logic [4:0] abort_at;
  logic [31:0] instr_addr, base_value, rf_rdata, mem_rdata, mem_addr, mem_wdata;
  logic [31:0] rf_wdata, base_wdata;
  logic [31:0] regs [16];
  bdt_pkg::bdt_instr_t instr;
  bdt_pkg::bdt_cycle_t cycle_kind;
  int n_errors = 0;
  int tests_run = 0;

  bdt_unit i_bdt_unit (.clk, .nrst, .start, .instr, .instr_addr, .base_value, .rf_rdata,
    .mem_rdata, .mem_abort, .busy, .done, .abort_trap, .mem_req, .mem_write, .mem_addr,
    .mem_wdata, .cycle_kind, .rf_raddr, .rf_user, .rf_we, .rf_widx, .rf_wdata, .base_we,
    .base_widx, .base_wdata, .psr_restore);
  bdt_mem_model i_bdt_mem_model (.clk, .nrst, .start, .mem_req, .mem_addr, .abort_at,
    .mem_rdata, .mem_abort, .nxfer());

  logic rf_load;
  logic [31:0] rf_init [16];

  // Register file: one process owns it; preload wins, base port after load port
  assign rf_rdata = regs[rf_raddr];
  always @(posedge clk) begin
    if (rf_load) begin
      regs <= rf_init;
    end else begin
      if (rf_we) regs[rf_widx] <= rf_wdata;
      if (base_we) regs[base_widx] <= base_wdata;
    end
  end

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic close_out();
    $display("tests_run=%0d n_errors=%0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One instruction: drive, watch every cycle, then compare the register file
  task automatic run_op(input logic ld, pr, u, s, w, input logic [3:0] b,
      input logic [15:0] lst, input logic [31:0] base, input logic [4:0] ab);
    int n, k, cyc, nwe, npsr;
    int nk [4];
    int ord [16];
    logic pc, abrt;
    logic [31:0] lo, wbv, ea, ed;
    logic [31:0] er [16];
    n = $countones(lst);
    k = 0;
    nwe = 0;
    npsr = 0;
    nk = '{default: 0};
    pc = ld && lst[15];
    abrt = ab < n;
    lo = u ? (pr ? base + 32'h4 : base) : base - 32'(4 * n) + (pr ? 32'h0 : 32'h4);
    wbv = u ? base + 32'(4 * n) : base - 32'(4 * n);
    for (int i = 0; i < 16; i++) begin
      if (lst[i]) begin
        ord[k] = i;
        k++;
      end
      er[i] = (i == b) ? base : 32'h0a00_0000 + 32'(i);
    end
    k = 0;
    @(posedge clk);
    for (int i = 0; i < 16; i++) rf_init[i] <= er[i];
    rf_load <= 1'b1;
    instr <= '{load: ld, pre: pr, up: u, sbit: s, wback: w, base_idx: b, reg_list: lst};
    instr_addr <= 32'h0000_2000;
    base_value <= base;
    abort_at <= ab;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    rf_load <= 1'b0;
    cyc = 0;
    do begin
      @(negedge clk);
      cyc++;
      if (busy === 1'b1) nk[cycle_kind]++;
      if (mem_req === 1'b1) begin
        ea = lo + 32'(4 * k);
        check(mem_addr, ea);
        check(mem_write, !ld);
        check(rf_user, s && !pc);
        if (!ld) begin
          ed = (ord[k] == 15) ? 32'h0000_200c : (ord[k] == b && w && k > 0) ? wbv : er[ord[k]];
          check(mem_wdata, ed);
        end else if (k < ab) begin
          er[ord[k]] = ~ea;
        end
        k++;
      end
      nwe += int'(rf_we);
      npsr += int'(psr_restore);
    end while (done !== 1'b1 && cyc < 80);
    check(done, 1'b1);
    check(busy, 1'b0);
    check(abort_trap, abrt);
    check(k, n);
    check(npsr, ld && s && pc && !abrt);
    check(nwe, ld ? (abrt ? ab : n) : 0);
    if (!abrt) begin
      check(cyc, ld ? (pc ? n + 5 : n + 3) : n + 2);
      check(nk[1], (ld && !pc) ? 1 : 2);
      check(nk[2], ld ? (pc ? n + 1 : n) : n - 1);
      check(nk[0], ld);
    end
    if (!(ld && lst[b] && !abrt)) er[b] = w ? wbv : base;
    @(negedge clk);
    for (int i = 0; i < 16; i++) check(regs[i], er[i]);
  endtask : run_op

  // Watchdog: about twenty instructions of under sixty cycles each
  initial begin
    #(25 * 4000);
    n_errors++;
    close_out();
  end

  initial begin
    nrst = 1'b0;
    start = 1'b0;
    instr = '0;
    instr_addr = 32'h0;
    base_value = 32'h0;
    abort_at = 5'h1f;
    rf_load = 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    // All eight load/store, pre/post, up/down combinations
    for (int m = 0; m < 8; m++) begin
      run_op(m[2], m[1], m[0], 0, 1, 4'h2, 16'h00a2, 32'h1000, 5'h1f);
    end
    run_op(0, 0, 1, 0, 1, 4'h1, 16'h00a2, 32'h1000, 5'h1f);
    run_op(0, 1, 0, 0, 1, 4'h5, 16'h00a2, 32'h1000, 5'h1f);
    // Single word store: the shortest store, base stored first
    run_op(0, 1, 1, 0, 1, 4'h6, 16'h0040, 32'h1000, 5'h1f);
    run_op(0, 0, 1, 0, 0, 4'h3, 16'h8003, 32'h1002, 5'h1f);
    run_op(0, 1, 0, 1, 0, 4'hd, 16'h40f0, 32'h3000, 5'h1f);
    run_op(1, 0, 1, 1, 1, 4'hd, 16'h8010, 32'h3000, 5'h1f);
    run_op(1, 0, 1, 1, 0, 4'h3, 16'h0f00, 32'h1000, 5'h1f);
    run_op(1, 1, 1, 0, 1, 4'h2, 16'h0024, 32'h1000, 5'h1f);
    run_op(1, 0, 1, 0, 0, 4'h0, 16'h0001, 32'h1000, 5'h1f);
    run_op(1, 0, 0, 0, 1, 4'hd, 16'hffff, 32'h4000, 5'h1f);
    // Aborts: load after base was overwritten, load and store on their first word
    run_op(1, 0, 1, 0, 1, 4'h2, 16'h0016, 32'h1000, 5'h02);
    run_op(1, 0, 1, 0, 0, 4'h1, 16'h8006, 32'h1000, 5'h00);
    run_op(0, 0, 1, 0, 1, 4'h4, 16'h0030, 32'h1000, 5'h00);
    close_out();
  end
endmodule : bdt_unit_tb
`default_nettype wire
